/* File: hw/isw_pkg.sv */
// Shared constants and types for the four-channel switch controller and its bus master
package isw_pkg;

	// ----------------------------------------------------------------
	// Register layout
	// ----------------------------------------------------------------
	localparam int ISW_CH_COUNT = 4;
	localparam int ISW_SEL_LSB = 0;
	localparam int ISW_IRQ_LSB = 4;
	localparam logic [3:0] ISW_SEL_RESET = 4'h0;
	localparam logic [4:0] ISW_ADDR_UPPER_DEF = 5'h1c;

	// ----------------------------------------------------------------
	// Serial framing
	// ----------------------------------------------------------------
	localparam logic [3:0] ISW_BYTE_LAST = 4'h7;
	localparam logic [3:0] ISW_ACK_SLOT = 4'h8;
	localparam logic [3:0] ISW_SLOT_END = 4'h9;
	localparam int ISW_FRAME_BITS = 18;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int ISW_CLK_PERIOD_NS = 5;
	localparam int ISW_SCL_MAX_KHZ = 400;
	localparam int ISW_SCL_PERIOD_NS = 1000000 / ISW_SCL_MAX_KHZ;
	// Quarter of the fastest bus period, rounded up so the bus never runs too fast
	localparam int ISW_QTR_CYCLES =
		(ISW_SCL_PERIOD_NS + 4 * ISW_CLK_PERIOD_NS - 1) / (4 * ISW_CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {DEV_IDLE, DEV_ADDR, DEV_WRITE, DEV_READ} isw_dev_st_t;
	typedef enum logic [1:0] {HST_IDLE, HST_START, HST_BITS, HST_STOP} isw_hst_st_t;

endpackage : isw_pkg

/* File: hw/isw_link_if.sv */
// Two-wire link between the bus master end and the switch controller end
interface isw_link_if;
	logic scl;
	logic m_sda_out;
	logic m_sda_oe_n;
	logic s_sda_out;
	logic s_sda_oe_n;
	logic sda_line;

	// Open-drain resolution: the line is low while any enabled driver pulls low
	assign sda_line = ~((~m_sda_oe_n & ~m_sda_out) | (~s_sda_oe_n & ~s_sda_out));

	modport master (
		output scl,
		output m_sda_out,
		output m_sda_oe_n,
		input sda_line
	);

	modport slave (
		input scl,
		input sda_line,
		output s_sda_out,
		output s_sda_oe_n
	);
endinterface : isw_link_if

/* File: hw/isw_dev.sv */
// Serial slave end: channel select register, stop-gated switching and irq summary
module isw_dev
	import isw_pkg::*;
#(
	parameter logic [4:0] ADDR_UPPER = ISW_ADDR_UPPER_DEF
)
(
	isw_link_if.slave link,
	input wire logic clk,
	input wire logic srst,
	input wire logic rst_pin_n,
	input wire logic addr_pin_lo,
	input wire logic addr_pin_hi,
	input wire logic ch0_irq_in_n,
	input wire logic ch1_irq_in_n,
	input wire logic ch2_irq_in_n,
	input wire logic ch3_irq_in_n,
	output logic [ISW_CH_COUNT-1:0] ch_enable,
	output logic irq_out,
	output logic irq_oe_n
);

	// ----------------------------------------------------------------
	// Link clock domain
	// ----------------------------------------------------------------
	logic [7:0] link_shift;

	// Data is captured on the bus clock itself; it stays still for a whole
	// bus phase, which is what lets the system side read it after a sync delay
	always_ff @(posedge link.scl)
	begin
		link_shift <= {link_shift[6:0], link.sda_line};
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic scl_m;
	logic scl_s;
	logic sda_m;
	logic sda_s;
	logic rst_m;
	logic rst_s;
	logic [1:0] addr_m;
	logic [1:0] addr_s;
	logic [3:0] irq_m;
	logic [3:0] irq_s;

	// Two flops on every pin; bus, reset pin and irq levels reset high so reset looks like an idle bus, address pins reset low
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			rst_m <= 1'b1;
			rst_s <= 1'b1;
			addr_m <= 2'h0;
			addr_s <= 2'h0;
			irq_m <= 4'hf;
			irq_s <= 4'hf;
		end
		else
		begin
			scl_m <= link.scl;
			scl_s <= scl_m;
			sda_m <= link.sda_line;
			sda_s <= sda_m;
			rst_m <= rst_pin_n;
			rst_s <= rst_m;
			addr_m <= {addr_pin_hi, addr_pin_lo};
			addr_s <= addr_m;
			irq_m <= {ch3_irq_in_n, ch2_irq_in_n, ch1_irq_in_n, ch0_irq_in_n};
			irq_s <= irq_m;
		end
	end

	// ----------------------------------------------------------------
	// Bus event decode
	// ----------------------------------------------------------------
	logic scl_q;
	logic sda_q;
	logic core_rst;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic byte_done;
	logic addr_match;
	logic [7:0] status_word;

	// Previous synchronised levels for edge detection
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// Power-on reset and the reset pin act alike on the sequencer, select registers, read data and data drive
	assign core_rst = srst | ~rst_s;
	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	// Data edges while the clock stays high mark frame boundaries
	assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
	assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;

	// ----------------------------------------------------------------
	// Slave sequencer
	// ----------------------------------------------------------------
	isw_dev_st_t state;
	logic [3:0] bit_cnt;
	logic rw_read;
	logic [3:0] ctrl_sel;
	logic [3:0] active_sel;
	logic [7:0] rd_byte;
	logic sda_oe_n;

	assign byte_done = scl_rise && (bit_cnt == ISW_BYTE_LAST);
	assign addr_match = (link_shift[7:1] == {ADDR_UPPER, addr_s[1], addr_s[0]});
	// Irq status is the inverted pin level, live at the moment of loading
	assign status_word = {~irq_s, ctrl_sel};

	// Frame state and bit position; start always restarts the address phase
	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			state <= DEV_IDLE;
			bit_cnt <= 4'h0;
			rw_read <= 1'b0;
		end
		else if (bus_start)
		begin
			state <= DEV_ADDR;
			bit_cnt <= 4'h0;
		end
		else if (bus_stop)
		begin
			state <= DEV_IDLE;
			bit_cnt <= 4'h0;
		end
		else
		begin
			if (scl_rise)
			begin
				bit_cnt <= bit_cnt + 4'h1;
			end
			else if (scl_fall && bit_cnt == ISW_SLOT_END)
			begin
				bit_cnt <= 4'h0;
			end
			case (state)
				DEV_ADDR:
				begin
					if (byte_done)
					begin
						if (!addr_match)
						begin
							state <= DEV_IDLE;
						end
						rw_read <= link_shift[0];
					end
					else if (scl_fall && bit_cnt == ISW_SLOT_END)
					begin
						state <= rw_read ? DEV_READ : DEV_WRITE;
					end
				end
				DEV_READ:
				begin
					// Master not acknowledging ends the read; wait for stop
					if (scl_rise && bit_cnt == ISW_ACK_SLOT && sda_s)
					begin
						state <= DEV_IDLE;
					end
				end
				DEV_WRITE:
				begin
					state <= DEV_WRITE;
				end
				default:
				begin
					state <= DEV_IDLE;
				end
			endcase
		end
	end

	// Control register and the live selection; the live copy only follows on stop
	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			ctrl_sel <= ISW_SEL_RESET;
			active_sel <= ISW_SEL_RESET;
		end
		else
		begin
			if (state == DEV_WRITE && byte_done)
			begin
				// Every byte overwrites, so the last one of a frame stays
				ctrl_sel <= link_shift[ISW_SEL_LSB +: 4];
			end
			if (bus_stop)
			begin
				active_sel <= ctrl_sel;
			end
		end
	end

	// Read data: reloaded at each byte slot so status is always fresh
	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			rd_byte <= 8'h00;
		end
		else if (scl_fall && bit_cnt == ISW_SLOT_END)
		begin
			rd_byte <= status_word;
		end
		else if (scl_fall && state == DEV_READ && bit_cnt < ISW_ACK_SLOT)
		begin
			rd_byte <= {rd_byte[6:0], 1'b0};
		end
	end

	// Data line drive: changes only after a clock fall, so it is steady while high
	always_ff @(posedge clk)
	begin
		if (core_rst || bus_start || bus_stop)
		begin
			sda_oe_n <= 1'b1;
		end
		else if (scl_fall)
		begin
			if ((state == DEV_ADDR || state == DEV_WRITE) && bit_cnt == ISW_ACK_SLOT)
			begin
				sda_oe_n <= 1'b0;
			end
			else if (bit_cnt == ISW_SLOT_END && (state == DEV_READ || (state == DEV_ADDR
				&& rw_read)))
			begin
				sda_oe_n <= status_word[7];
			end
			else if (state == DEV_READ && bit_cnt != 4'h0 && bit_cnt < ISW_ACK_SLOT)
			begin
				sda_oe_n <= rd_byte[6];
			end
			else
			begin
				sda_oe_n <= 1'b1;
			end
		end
	end

	// Irq summary: pulled low while any input is low, selected or not
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			irq_oe_n <= 1'b1;
		end
		else
		begin
			irq_oe_n <= &irq_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ch_enable = active_sel;
	assign irq_out = 1'b0;
	assign link.s_sda_out = 1'b0;
	assign link.s_sda_oe_n = sda_oe_n;

endmodule : isw_dev

/* File: hw/isw_host.sv */
// Bus master end: one-byte register write or read frames on the two-wire link
module isw_host
	import isw_pkg::*;
#(
	parameter int QTR_CYCLES = ISW_QTR_CYCLES
)
(
	isw_link_if.master link,
	input wire logic clk,
	input wire logic srst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [6:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic rsp_ack
);

	localparam int QW = $clog2(QTR_CYCLES + 1);

	// Below two cycles a quarter phase would not cover the far end's sync delay
	if (QTR_CYCLES < 2)
	begin : g_bad_qtr
		$error("isw_host: QTR_CYCLES must be at least 2");
	end

	// ----------------------------------------------------------------
	// Phase timing
	// ----------------------------------------------------------------
	isw_hst_st_t state;
	logic [QW-1:0] qcnt;
	logic tick;
	logic [1:0] ph;
	logic [4:0] bit_idx;
	logic sda_m;
	logic sda_s;

	assign tick = (qcnt == QW'(QTR_CYCLES - 1));
	assign cmd_ready = (state == HST_IDLE);

	// Quarter-period counter; the bus clock is derived from it
	always_ff @(posedge clk)
	begin
		if (srst || state == HST_IDLE || tick)
		begin
			qcnt <= '0;
		end
		else
		begin
			qcnt <= qcnt + QW'(1);
		end
	end

	// Returning data line passes two flops before use
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end
		else
		begin
			sda_m <= link.sda_line;
			sda_s <= sda_m;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	// Start, address and direction first, then one data byte, then stop
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= HST_IDLE;
			ph <= 2'h0;
			bit_idx <= 5'h00;
		end
		else
		begin
			case (state)
				HST_IDLE:
				begin
					ph <= 2'h0;
					if (cmd_valid)
					begin
						state <= HST_START;
					end
				end
				HST_START:
				begin
					if (tick)
					begin
						ph <= (ph == 2'h1) ? 2'h0 : ph + 2'h1;
						bit_idx <= 5'h00;
						if (ph == 2'h1)
						begin
							state <= HST_BITS;
						end
					end
				end
				HST_BITS:
				begin
					if (tick)
					begin
						ph <= ph + 2'h1;
						if (ph == 2'h3)
						begin
							if (bit_idx == 5'(ISW_FRAME_BITS - 1))
							begin
								state <= HST_STOP;
							end
							bit_idx <= bit_idx + 5'h01;
						end
					end
				end
				HST_STOP:
				begin
					if (tick)
					begin
						ph <= ph + 2'h1;
						if (ph == 2'h3)
						begin
							state <= HST_IDLE;
						end
					end
				end
				default:
				begin
					state <= HST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Line drive and data capture
	// ----------------------------------------------------------------
	logic scl_r;
	logic oe_n_r;
	logic [ISW_FRAME_BITS-1:0] tx;
	logic [ISW_FRAME_BITS-1:0] rx;
	logic is_read;

	// Clock and data: data moves only while the clock is low, except at start/stop
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scl_r <= 1'b1;
			oe_n_r <= 1'b1;
		end
		else if (tick)
		begin
			case (state)
				HST_START:
				begin
					if (ph == 2'h0)
					begin
						oe_n_r <= 1'b0;
					end
					else
					begin
						scl_r <= 1'b0;
					end
				end
				HST_BITS:
				begin
					if (ph == 2'h0)
					begin
						oe_n_r <= tx[ISW_FRAME_BITS-1];
					end
					else if (ph == 2'h1)
					begin
						scl_r <= 1'b1;
					end
					else if (ph == 2'h3)
					begin
						scl_r <= 1'b0;
					end
				end
				HST_STOP:
				begin
					if (ph == 2'h0)
					begin
						oe_n_r <= 1'b0;
					end
					else if (ph == 2'h1)
					begin
						scl_r <= 1'b1;
					end
					else if (ph == 2'h2)
					begin
						oe_n_r <= 1'b1;
					end
				end
				default:
				begin
					scl_r <= 1'b1;
					oe_n_r <= 1'b1;
				end
			endcase
		end
	end

	// Frame image: ones release the line for acknowledges, read data and final not-ack
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tx <= '0;
			rx <= '0;
			is_read <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
			rsp_ack <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			if (state == HST_IDLE && cmd_valid)
			begin
				tx <= {cmd_addr, cmd_read, 1'b1, cmd_read ? 8'hff : cmd_wdata, 1'b1};
				is_read <= cmd_read;
			end
			else if (state == HST_BITS && tick && ph == 2'h2)
			begin
				rx <= {rx[ISW_FRAME_BITS-2:0], sda_s};
			end
			else if (state == HST_BITS && tick && ph == 2'h3)
			begin
				tx <= {tx[ISW_FRAME_BITS-2:0], 1'b1};
			end
			else if (state == HST_STOP && tick && ph == 2'h3)
			begin
				rsp_valid <= 1'b1;
				rsp_rdata <= rx[8:1];
				rsp_ack <= ~rx[9] & (is_read | ~rx[0]);
			end
		end
	end

	// Bus clock is a flop output, so the far end sees a clean clock
	assign link.scl = scl_r;
	assign link.m_sda_out = 1'b0;
	assign link.m_sda_oe_n = oe_n_r;

endmodule : isw_host

/* File: tb/isw_monitor.sv */
// Concurrent checks on the two-wire link between the bus master end and the switch end
module isw_monitor
	import isw_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic m_sda_out,
	input wire logic m_sda_oe_n,
	input wire logic s_sda_out,
	input wire logic s_sda_oe_n,
	input wire logic sda_line
);
	timeunit 1ns;
	timeprecision 1ps;

	logic scl_q;
	logic sda_q;
	logic [4:0] rises;
	logic [5:0] hi_cnt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	// Clock rises since the last start; a start clears the count
	always_ff @(posedge clk)
	begin
		scl_q <= scl;
		sda_q <= sda_line;
		if (scl && scl_q && sda_q && !sda_line)
			rises <= 5'h00;
		else if (scl && !scl_q)
			rises <= rises + 5'h01;
	end

	// Clock-high run length; saturates so a long idle never wraps back to zero
	always_ff @(posedge clk)
		if (!scl)
			hi_cnt <= 6'h00;
		else if (hi_cnt != 6'h3f)
			hi_cnt <= hi_cnt + 6'h01;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	chk_idle_after_rst: assert property ($fell(srst) |-> scl && m_sda_oe_n && s_sda_oe_n)
		else $error("link not idle after reset");
	chk_scl_high_len: assert property ($rose(scl) |-> scl [*8])
		else $error("bus clock high phase too short");
	chk_scl_low_len: assert property ($fell(scl) |-> !scl [*8])
		else $error("bus clock low phase too short");
	chk_start_then_low: assert property (scl && $fell(sda_line) |-> ##[1:12] !scl)
		else $error("no clock after start");
	chk_dev_hold_high: assert property (scl && $past(scl) |-> $stable(s_sda_oe_n))
		else $error("switch end moved data while clock high");
	chk_no_early_drive: assert property ($fell(s_sda_oe_n) |-> !scl && rises >= 5'h08)
		else $error("switch end drove data inside the address byte");
	chk_idle_release: assert property (hi_cnt >= 6'h18 |-> s_sda_oe_n)
		else $error("switch end holds data low on an idle bus");
	// The stop's own clock rise comes after the frame's bit clocks, hence one more
	chk_frame_bits: assert property (scl && $past(scl) && $rose(sda_line) |->
		int'(rises) == ISW_FRAME_BITS + 1)
		else $error("stop seen after wrong bit count");
	chk_drive_zero: assert property (s_sda_out == 1'b0 && m_sda_out == 1'b0)
		else $error("open-drain value not low");
endmodule : isw_monitor

/* File: tb/tb_top.sv */
// Self-checking bench joining the bus master end and the switch end over the link
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic rd;
		logic [1:0] pins;
		logic [6:0] addr;
		logic [7:0] wd;
		logic [3:0] irq_n;
		logic ack;
		logic [7:0] rdata;
		logic [3:0] ch;
	} isw_row_t;

	logic clk = 1'b0;
	logic srst = 1'b1;
	logic rst_pin_n = 1'b1;
	logic [1:0] pins = 2'b01;
	logic [3:0] irq_n = 4'hf;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [6:0] cmd_addr = 7'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_ready;
	logic rsp_valid;
	logic rsp_ack;
	logic irq_out;
	logic irq_oe_n;
	logic [7:0] rsp_rdata;
	logic [3:0] ch_enable;
	int err_total = 0;
	int compares = 0;
	// Read byte is {~irq pins, selection}; pins 01 give address 71, pins 10 give 72
	isw_row_t rows [9] = '{
		{1'b0, 2'b01, 7'h71, 8'h05, 4'hf, 1'b1, 8'h00, 4'h5},
		{1'b1, 2'b01, 7'h71, 8'h00, 4'hf, 1'b1, 8'h05, 4'h5},
		{1'b0, 2'b01, 7'h72, 8'h0f, 4'hf, 1'b0, 8'h00, 4'h5},
		{1'b0, 2'b01, 7'h71, 8'hfa, 4'he, 1'b1, 8'h00, 4'ha},
		{1'b1, 2'b01, 7'h71, 8'h00, 4'he, 1'b1, 8'h1a, 4'ha},
		{1'b1, 2'b01, 7'h71, 8'h00, 4'h5, 1'b1, 8'haa, 4'ha},
		{1'b0, 2'b10, 7'h72, 8'h0f, 4'hf, 1'b1, 8'h00, 4'hf},
		{1'b0, 2'b10, 7'h71, 8'h00, 4'hf, 1'b0, 8'h00, 4'hf},
		{1'b1, 2'b10, 7'h72, 8'h00, 4'h0, 1'b1, 8'hff, 4'hf}
	};

	isw_link_if link ();

	isw_host #(.QTR_CYCLES(8)) i_isw_host (.link(link), .clk(clk), .srst(srst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_ack(rsp_ack));

	isw_dev i_isw_dev (.link(link), .clk(clk), .srst(srst), .rst_pin_n(rst_pin_n),
		.addr_pin_lo(pins[0]), .addr_pin_hi(pins[1]), .ch0_irq_in_n(irq_n[0]),
		.ch1_irq_in_n(irq_n[1]), .ch2_irq_in_n(irq_n[2]), .ch3_irq_in_n(irq_n[3]),
		.ch_enable(ch_enable), .irq_out(irq_out), .irq_oe_n(irq_oe_n));

	isw_monitor i_isw_monitor (.clk(clk), .srst(srst), .scl(link.scl),
		.m_sda_out(link.m_sda_out), .m_sda_oe_n(link.m_sda_oe_n),
		.s_sda_out(link.s_sda_out), .s_sda_oe_n(link.s_sda_oe_n), .sda_line(link.sda_line));

	// 200 MHz system clock
	initial
		forever #2.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_byte

	// Valid stays up across one rising edge; the master is idle, so ready is high there
	task automatic issue_cmd(input logic rd, input logic [6:0] addr, input logic [7:0] wd);
		@(negedge clk);
		cmd_read = rd;
		cmd_addr = addr;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask : issue_cmd

	// Bounded wait: a frame takes about 630 cycles at this quarter length
	task automatic wait_rsp();
		int n = 0;
		while (rsp_valid !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 2000)
			err_total++;
	endtask : wait_rsp

	task automatic test_done();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (8) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		cmp_byte({4'h0, ch_enable}, 8'h00);
		cmp_bit(irq_oe_n, 1'b1);
		cmp_bit(irq_out, 1'b0);
		foreach (rows[i])
		begin
			pins = rows[i].pins;
			irq_n = rows[i].irq_n;
			repeat (6) @(negedge clk);
			cmp_bit(irq_oe_n, &rows[i].irq_n);
			issue_cmd(rows[i].rd, rows[i].addr, rows[i].wd);
			cmp_bit(cmd_ready, 1'b0);
			wait_rsp();
			cmp_bit(cmd_ready, 1'b1);
			cmp_bit(rsp_ack, rows[i].ack);
			if (rows[i].rd)
				cmp_byte(rsp_rdata, rows[i].rdata);
			repeat (8) @(negedge clk);
			cmp_byte({4'h0, ch_enable}, {4'h0, rows[i].ch});
		end
		// Late in the frame the byte is in, but the stop has not come yet
		irq_n = 4'hf;
		issue_cmd(1'b0, 7'h72, 8'h03);
		repeat (560) @(negedge clk);
		cmp_byte({4'h0, ch_enable}, 8'h0f);
		wait_rsp();
		repeat (8) @(negedge clk);
		cmp_byte({4'h0, ch_enable}, 8'h03);
		// Flag on channel 2: read it, select that channel, then read again
		irq_n = 4'hb;
		repeat (6) @(negedge clk);
		issue_cmd(1'b1, 7'h72, 8'h00);
		wait_rsp();
		cmp_byte(rsp_rdata, 8'h43);
		issue_cmd(1'b0, 7'h72, 8'h04);
		wait_rsp();
		repeat (8) @(negedge clk);
		cmp_byte({4'h0, ch_enable}, 8'h04);
		// The status bit stays set while the channel's irq input is still low
		issue_cmd(1'b1, 7'h72, 8'h00);
		wait_rsp();
		cmp_byte(rsp_rdata, 8'h44);
		irq_n = 4'hf;
		// Reset pin between frames, held past its two-stage synchroniser
		rst_pin_n = 1'b0;
		repeat (4) @(negedge clk);
		rst_pin_n = 1'b1;
		repeat (4) @(negedge clk);
		cmp_byte({4'h0, ch_enable}, 8'h00);
		issue_cmd(1'b1, 7'h72, 8'h00);
		wait_rsp();
		cmp_byte(rsp_rdata, 8'h00);
		test_done();
	end

	// About four and a half times the expected run before a hang is cut short
	initial
	begin
		#200000;
		err_total++;
		test_done();
	end
endmodule : tb_top
